/* hw/crf_formatter.sv */
// Capture record formatter: timestamp clock, record builder and APB slave
module crf_formatter #(
	parameter int P_SECOND_CYC = crf_pkg::CLK_HZ,
	parameter int P_BUF_BYTES = crf_pkg::CELL_BYTES
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_last,
	input wire logic i_rx_err,
	input wire logic i_rx_int_err,
	output logic o_rec_valid,
	output logic [7:0] o_rec_data,
	output logic o_rec_last,
	input wire logic i_rec_ready,
	input wire logic i_second_pulse_a,
	input wire logic i_time_serial_b,
	output logic o_sync_out_a,
	output logic o_sync_out_b
);
	typedef struct packed {
		crf_pkg::crf_st_t state;
		logic [7:0] ctrl;
		logic [31:0] sec;
		logic [crf_pkg::FRAC_ACT-1:0] frac;
		logic [24:0] acc;
		logic a_m;
		logic a_s;
		logic a_d;
		logic b_m;
		logic b_s;
		logic [24:0] per;
		logic locked;
		logic [7:0] pulse_cnt;
		logic pout;
		logic in_pkt;
		logic dropping;
		logic [15:0] loss;
		logic [15:0] loss_rec;
		logic [63:0] ts;
		logic [P_BUF_BYTES-1:0][7:0] buf_b;
		logic [7:0] n;
		logic [15:0] wlen;
		logic [7:0] flg;
		logic [7:0] kind;
		logic pad;
		logic [7:0] idx;
		logic [7:0] rlen;
		logic ovalid;
		logic [7:0] odata;
		logic olast;
		logic [31:0] prdata;
		logic pslverr;
	} crf_state_t;

	localparam logic [24:0] PERIOD = 25'(P_SECOND_CYC);
	// Fraction steps per cycle, split into a whole part and a remainder.
	// A short simulated second gives a large whole part, the real clock
	// gives none; both add exactly one second over P_SECOND_CYC cycles.
	localparam logic [23:0] FRAC_Q =
		24'((1 << crf_pkg::FRAC_ACT) / P_SECOND_CYC);
	localparam logic [24:0] FRAC_R =
		25'((1 << crf_pkg::FRAC_ACT) % P_SECOND_CYC);
	localparam int FRAC_TOP = crf_pkg::FRAC_ACT - 1;
	localparam logic [24:0] WIN_LO = 25'(P_SECOND_CYC - crf_pkg::SYNC_TOL_CYC);
	localparam logic [24:0] WIN_HI = 25'(P_SECOND_CYC + crf_pkg::SYNC_TOL_CYC);
	localparam logic [7:0] BUF_N = 8'(P_BUF_BYTES);
	localparam logic [7:0] PULSE_N = 8'(crf_pkg::OUT_PULSE_CYC);

	crf_state_t s_r;
	crf_state_t s_nxt;

	// One record byte by index; header is fixed, body follows
	function automatic logic [7:0] crf_byte(input crf_state_t s,
		input logic [7:0] i);
		logic [7:0] bi;
		logic [7:0] b;
		bi = i - crf_pkg::HDR_BYTES - {7'h00, s.pad};
		b = 8'h00;
		if (i < crf_pkg::TS_BYTES)
			b = s.ts[{i[2:0], 3'h0} +: 8]; // Low byte first
		else if (i == 8'h08)
			b = s.kind;
		else if (i == 8'h09)
			b = s.flg;
		else if (i == 8'h0A)
			b = 8'h00; // Length fits in low byte, high byte first
		else if (i == 8'h0B)
			b = s.rlen;
		else if (i == 8'h0C)
			b = s.loss_rec[15:8];
		else if (i == 8'h0D)
			b = s.loss_rec[7:0];
		else if (i == 8'h0E)
			b = s.wlen[15:8];
		else if (i == 8'h0F)
			b = s.wlen[7:0];
		else if (s.pad && i == crf_pkg::HDR_BYTES)
			b = 8'h00; // Alignment pad ahead of a LAN frame
		else if (bi < BUF_N)
			b = s.buf_b[bi]; // Body in arrival order
		return b;
	endfunction

	always_comb
	begin
		logic [24:0] step;
		logic carry;
		logic wrap;
		logic edge_a;
		logic first;
		logic take;
		logic [7:0] nn;
		s_nxt = s_r;
		step = 25'h0000000;
		carry = 1'b0;
		edge_a = 1'b0;
		wrap = 1'b0;
		first = 1'b0;
		take = 1'b0;
		nn = 8'h00;

		// Pin inputs pass two flops; a_d only remembers the synced level
		s_nxt.a_m = i_second_pulse_a;
		s_nxt.a_s = s_r.a_m;
		s_nxt.a_d = s_r.a_s;
		s_nxt.b_m = i_time_serial_b;
		s_nxt.b_s = s_r.b_m;
		edge_a = s_r.a_s & ~s_r.a_d;

		// Phase accumulator: the whole quotient goes in every cycle and the
		// remainder adds one extra step when it overflows; one carry per
		// cycle alone would run slow whenever the clock is below 2^23 Hz
		step = s_r.acc + FRAC_R;
		if (step >= PERIOD)
		begin
			s_nxt.acc = step - PERIOD;
			carry = 1'b1;
		end
		else
			s_nxt.acc = step;
		{wrap, s_nxt.frac} = {1'b0, s_r.frac} + FRAC_Q +
			{23'h000000, carry};
		if (wrap)
			s_nxt.sec = s_r.sec + 32'h00000001;

		// Pulse interval check; an in-window pulse snaps to the second.
		// A pulse outside the window only restarts the interval count, so it never drags the clock;
		// an in-window pulse snaps it, and the lock drops only after a silence past the window.
		if (s_r.per != 25'h1FFFFFF)
			s_nxt.per = s_r.per + 25'h0000001;
		if (edge_a)
		begin
			s_nxt.per = 25'h0000000;
			if (s_r.per >= WIN_LO && s_r.per <= WIN_HI)
			begin
				// Lock without software help; round to the nearest second
				s_nxt.locked = 1'b1;
				s_nxt.sec = s_r.sec + {31'h00000000, s_r.frac[FRAC_TOP]};
				s_nxt.frac = '0;
				s_nxt.acc = 25'h0000000;
				wrap = 1'b0;
			end
		end
		else if (s_r.per > WIN_HI)
			s_nxt.locked = 1'b0;

		// Master output pulse at each fraction roll-over; a snap to an in-window pulse gives none
		if (s_r.pulse_cnt != 8'h00)
			s_nxt.pulse_cnt = s_r.pulse_cnt - 8'h01;
		if (wrap && s_r.ctrl[crf_pkg::CTRL_MASTER_BIT])
			s_nxt.pulse_cnt = PULSE_N;
		s_nxt.pout = s_r.ctrl[crf_pkg::CTRL_MASTER_BIT] &&
			s_nxt.pulse_cnt != 8'h00;

		// APB write at the access phase; seconds load restarts the fraction
		if (i_psel && i_penable && i_pwrite)
		begin
			if (i_paddr == crf_pkg::ADDR_CTRL)
				s_nxt.ctrl = {1'b0, i_pwdata[6:0]};
			else if (i_paddr == crf_pkg::ADDR_SECONDS)
			begin
				s_nxt.sec = i_pwdata; // Host supplies UTC seconds
				s_nxt.frac = '0;
				s_nxt.acc = 25'h0000000;
			end
		end

		// APB read data prepared in the setup phase, unmapped flags error
		if (i_psel && !i_penable)
		begin
			s_nxt.pslverr = 1'b0;
			s_nxt.prdata = 32'h00000000;
			if (i_paddr == crf_pkg::ADDR_CTRL)
				s_nxt.prdata = {24'h000000, s_r.ctrl};
			else if (i_paddr == crf_pkg::ADDR_SECONDS)
				s_nxt.prdata = s_r.sec;
			else if (i_paddr == crf_pkg::ADDR_STATUS)
			begin
				s_nxt.prdata[crf_pkg::STAT_LOCK_BIT] = s_r.locked;
				s_nxt.prdata[crf_pkg::STAT_B_BIT] = s_r.b_s;
				s_nxt.prdata[crf_pkg::STAT_LOSS_LSB +: 16] = s_r.loss;
			end
			else if (i_paddr == crf_pkg::ADDR_FRACTION)
				s_nxt.prdata = {s_r.frac, {crf_pkg::FRAC_ZERO{1'b0}}};
			else
				s_nxt.pslverr = 1'b1;
		end

		// Packet boundary tracking, also for packets that are dropped
		if (i_rx_valid)
		begin
			first = !s_r.in_pkt;
			s_nxt.in_pkt = !i_rx_last;
		end

		// First byte: start a record if idle and enabled, else count a loss
		if (first)
		begin
			if (s_r.state == crf_pkg::ST_IDLE &&
				s_r.ctrl[crf_pkg::CTRL_ENABLE_BIT])
			begin
				take = 1'b1;
				s_nxt.dropping = 1'b0;
				s_nxt.state = crf_pkg::ST_CAP;
				// One timestamp per record, taken on arrival
				s_nxt.ts = {s_r.sec, s_r.frac,
					{crf_pkg::FRAC_ZERO{1'b0}}};
				s_nxt.loss_rec = s_r.loss;
				s_nxt.loss = 16'h0000;
				s_nxt.n = 8'h00;
				s_nxt.wlen = 16'h0000;
				s_nxt.flg = 8'h00; // Reserved bits stay zero
				s_nxt.flg[1:0] = s_r.ctrl[crf_pkg::CTRL_IFACE_LSB +: 2];
				s_nxt.flg[crf_pkg::FLG_VARY] =
					s_r.ctrl[crf_pkg::CTRL_VARY_BIT];
				s_nxt.pad = 1'b0;
				unique case (s_r.ctrl[crf_pkg::CTRL_MODE_LSB +: 2])
					crf_pkg::MODE_LAN:
					begin
						s_nxt.kind = crf_pkg::kind_lan_frame;
						s_nxt.pad = 1'b1;
					end
					crf_pkg::MODE_FRAMED:
						s_nxt.kind = crf_pkg::kind_framed;
					default:
						s_nxt.kind = crf_pkg::kind_cell;
				endcase
			end
			else
			begin
				s_nxt.dropping = 1'b1;
				if (s_r.loss != crf_pkg::LOSS_MAX)
					s_nxt.loss = s_r.loss + 16'h0001;
			end
		end

		// Store bytes; overflow beyond the buffer marks truncation.
		// A long cell keeps its first stored bytes, so the cell-size check
		// below only marks cells that ended short of the full size.
		if (i_rx_valid && (take || (s_r.state == crf_pkg::ST_CAP &&
			!s_r.dropping)))
		begin
			nn = s_nxt.n;
			if (s_nxt.wlen != 16'hFFFF)
				s_nxt.wlen = s_nxt.wlen + 16'h0001; // Every wire byte
			if (nn < BUF_N)
			begin
				s_nxt.buf_b[nn] = i_rx_data;
				nn = nn + 8'h01;
			end
			else
				s_nxt.flg[crf_pkg::FLG_TRUNC] = 1'b1;
			s_nxt.n = nn;
			if (i_rx_err)
				s_nxt.flg[crf_pkg::FLG_RX_ERR] = 1'b1;
			if (i_rx_int_err)
				s_nxt.flg[crf_pkg::FLG_INT_ERR] = 1'b1; // internal_fault_flag
			if (i_rx_last)
			begin
				// A cell must be header plus payload, exactly
				if (s_nxt.kind == crf_pkg::kind_cell &&
					nn != 8'(crf_pkg::CELL_BYTES))
					s_nxt.flg[crf_pkg::FLG_INT_ERR] = 1'b1;
				// Total bytes handed to the host
				s_nxt.rlen = crf_pkg::HDR_BYTES + {7'h00, s_nxt.pad} + nn;
				s_nxt.state = crf_pkg::ST_EMIT;
				s_nxt.idx = 8'h00;
				s_nxt.ovalid = 1'b1;
				s_nxt.olast = 1'b0;
				s_nxt.odata = crf_byte(s_nxt, 8'h00);
			end
		end

		// Emit bytes under back-pressure; the skip-offset field is absent
		if (s_r.state == crf_pkg::ST_EMIT && i_rec_ready)
		begin
			if (s_r.olast)
			begin
				s_nxt.state = crf_pkg::ST_IDLE;
				s_nxt.ovalid = 1'b0;
				s_nxt.olast = 1'b0;
			end
			else
			begin
				s_nxt.idx = s_r.idx + 8'h01;
				s_nxt.odata = crf_byte(s_r, s_r.idx + 8'h01);
				s_nxt.olast = (s_r.idx + 8'h02) == s_r.rlen;
			end
		end
	end

	// Single state register; reset gives idle, clock at zero
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			s_r <= '0;
			s_r.state <= crf_pkg::ST_IDLE;
			s_r.ctrl <= crf_pkg::CTRL_RESET;
		end
		else
			s_r <= s_nxt;
	end

	// Zero-wait slave: answer in the first access cycle
	assign o_pready = 1'b1;
	assign o_prdata = s_r.prdata;
	assign o_pslverr = s_r.pslverr & i_psel & i_penable;
	assign o_rec_valid = s_r.ovalid;
	assign o_rec_data = s_r.odata;
	assign o_rec_last = s_r.olast;
	assign o_sync_out_a = s_r.pout;
	// Serial time packet output is not generated
	assign o_sync_out_b = 1'b0;
endmodule

/* inc/crf_pkg.sv */
// Constants, field layout and state codes of the capture record formatter
package crf_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SECONDS = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_FRACTION = 8'h0C;
	// Control fields
	localparam int CTRL_IFACE_LSB = 0;
	localparam int CTRL_VARY_BIT = 2;
	localparam int CTRL_MODE_LSB = 3;
	localparam int CTRL_MASTER_BIT = 5;
	localparam int CTRL_ENABLE_BIT = 6;
	localparam logic [7:0] CTRL_RESET = 8'h40;
	localparam logic [1:0] MODE_CELL = 2'h0;
	localparam logic [1:0] MODE_LAN = 2'h1;
	localparam logic [1:0] MODE_FRAMED = 2'h2;
	// Status fields
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_B_BIT = 1;
	localparam int STAT_LOSS_LSB = 16;
	// Record kinds
	localparam logic [7:0] kind_legacy = 8'h00;
	localparam logic [7:0] kind_framed = 8'h01;
	localparam logic [7:0] kind_lan_frame = 8'h02;
	localparam logic [7:0] kind_cell = 8'h03;
	localparam logic [7:0] kind_reassembled_frame = 8'h04;
	localparam logic [7:0] kind_multichan_framed = 8'h05;
	localparam logic [7:0] kind_multichan_raw = 8'h06;
	localparam logic [7:0] kind_multichan_cell = 8'h07;
	// Flag bit positions
	localparam int FLG_VARY = 2;
	localparam int FLG_TRUNC = 3;
	localparam int FLG_RX_ERR = 4;
	localparam int FLG_INT_ERR = 5;
	// Record geometry
	localparam logic [7:0] HDR_BYTES = 8'h10;
	localparam logic [7:0] TS_BYTES = 8'h08;
	localparam int CELL_BYTES = 52;
	localparam logic [15:0] LOSS_MAX = 16'hFFFF;
	// Timestamp fraction: active bits and always-zero low bits
	localparam int FRAC_ACT = 23;
	localparam int FRAC_ZERO = 9;
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int OUT_PULSE_NS = 10_000;
	localparam int OUT_PULSE_CYC = OUT_PULSE_NS / (1_000_000_000 / CLK_HZ);
	localparam int SYNC_TOL_CYC = 1000;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CAP = 2'h1,
		ST_EMIT = 2'h3
	} crf_st_t;
endpackage

/* testbench/crf_formatter_assertions.sv */
// Port-level checks of the capture record formatter
module crf_formatter_assertions (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pslverr,
	input wire logic o_rec_valid,
	input wire logic [7:0] o_rec_data,
	input wire logic o_rec_last,
	input wire logic i_rec_ready,
	input wire logic o_sync_out_a
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] idx_r;
	logic acc;
	logic mapped;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	// Byte position in the record; header checks key off it
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			idx_r <= 8'h00;
		else if (o_rec_valid && i_rec_ready)
			idx_r <= o_rec_last ? 8'h00 : idx_r + 8'h01;
	end
	// Access phase and the four word-aligned register slots
	assign acc = i_psel && i_penable;
	assign mapped = i_paddr[7:4] == 4'h0 && i_paddr[1:0] == 2'h0;
	a_rec_hold: assert property (o_rec_valid && !i_rec_ready |=>
		o_rec_valid && $stable(o_rec_data) && $stable(o_rec_last))
		else $error("record byte changed while stalled");
	a_rec_end: assert property (o_rec_valid && i_rec_ready && o_rec_last
		|=> !o_rec_valid) else $error("valid after last byte");
	a_rec_length: assert property (o_rec_valid && o_rec_last |->
		idx_r >= 8'h10) else $error("record shorter than header");
	a_kind_byte: assert property (o_rec_valid && idx_r == 8'h08 |->
		o_rec_data inside {8'h01, 8'h02, 8'h03}) else $error("bad kind");
	a_flags_resv: assert property (o_rec_valid && idx_r == 8'h09 |->
		o_rec_data[7:6] == 2'h0) else $error("reserved flags set");
	a_rlen_order: assert property (o_rec_valid && idx_r == 8'h0A |->
		o_rec_data == 8'h00) else $error("length high byte wrong");
	a_ts_low: assert property (o_rec_valid && idx_r == 8'h00 |->
		o_rec_data == 8'h00) else $error("inactive fraction bits set");
	a_frac_zero: assert property (acc && !i_pwrite &&
		i_paddr == 8'h0C |-> o_prdata[8:0] == 9'h000)
		else $error("fraction low bits set");
	a_unmapped_err: assert property (acc |-> o_pslverr == !mapped)
		else $error("slave error wrong");
	a_sync_pulse: assert property ($rose(o_sync_out_a) |=>
		o_sync_out_a [*8]) else $error("sync pulse too short");
endmodule

/* testbench/crf_sink_model.sv */
// Host storage model taking the record stream
module crf_sink_model (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_stall,
	input wire logic i_slow,
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	input wire logic i_last,
	output logic o_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rec [0:127];
	int n;
	int recs;
	logic fresh;
	// Slow mode halves the rate so held bytes get exercised
	always @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_ready <= 1'b0;
			n <= 0;
			recs <= 0;
			fresh <= 1'b1;
		end
		else
		begin
			o_ready <= !i_stall && (!i_slow || !o_ready);
			if (i_valid && o_ready)
			begin
				rec[fresh ? 0 : n] <= i_data;
				n <= fresh ? 1 : n + 1;
				fresh <= i_last;
				recs <= recs + (i_last ? 1 : 0);
			end
		end
	end
endmodule

/* testbench/crf_formatter_tb.sv */
// Self-checking bench for the capture record formatter
module crf_formatter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SEC = 2000;
	logic i_clk, i_resetn, i_psel, i_penable, i_pwrite, err;
	logic [7:0] i_paddr, i_rx_data, o_rec_data;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic o_pready, o_pslverr, i_rx_valid, i_rx_last, i_rx_err;
	logic i_rx_int_err, o_rec_valid, o_rec_last, i_rec_ready;
	logic i_second_pulse_a, i_time_serial_b, o_sync_out_a, o_sync_out_b;
	logic stall, slow;
	int error_cnt, n_compared;
	crf_formatter #(.P_SECOND_CYC(SEC)) crf_formatter_inst (
		.i_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rx_valid,
		.i_rx_data, .i_rx_last, .i_rx_err, .i_rx_int_err, .o_rec_valid,
		.o_rec_data, .o_rec_last, .i_rec_ready, .i_second_pulse_a,
		.i_time_serial_b, .o_sync_out_a, .o_sync_out_b);
	crf_sink_model sink_inst (.i_clk, .i_resetn, .i_stall(stall),
		.i_slow(slow), .i_valid(o_rec_valid), .i_data(o_rec_data),
		.i_last(o_rec_last), .o_ready(i_rec_ready));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task tmo();
		error_cnt++;
		$display("ERROR %0t wait expired", $time);
		finish_test();
	endtask
	// APB transfer; read data and error taken at the ready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge i_clk);
			k++;
		end
		while (o_pready !== 1'b1 && k < 20);
		if (o_pready !== 1'b1)
			tmo();
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	// Link packet of n bytes 40h+i; e drives the two error inputs
	task send(input int n, input logic [1:0] e);
		for (int i = 0; i < n; i++)
		begin
			@(posedge i_clk);
			i_rx_valid <= 1'b1;
			i_rx_data <= 8'h40 + i[7:0];
			i_rx_last <= (i == n - 1);
			{i_rx_int_err, i_rx_err} <= e;
		end
		@(posedge i_clk);
		i_rx_valid <= 1'b0;
		i_rx_last <= 1'b0;
		i_rx_data <= ~i_rx_data;
	endtask
	task wait_rec(input int r);
		int k;
		k = 0;
		while (sink_inst.recs < r && k < 3000)
		begin
			@(posedge i_clk);
			k++;
		end
		if (sink_inst.recs < r)
			tmo();
	endtask
	task chk_rec(input logic [7:0] kd, fl, len, lc, wl, input int off);
		check(sink_inst.n, len);
		check(sink_inst.rec[8], kd);
		check(sink_inst.rec[9], fl);
		check({sink_inst.rec[10], sink_inst.rec[11]}, len);
		check({sink_inst.rec[12], sink_inst.rec[13]}, lc);
		check({sink_inst.rec[14], sink_inst.rec[15]}, wl);
		for (int i = 0; i < len - off; i++)
			check(sink_inst.rec[off + i], 8'h40 + i[7:0]);
	endtask
	task s_regs();
		apb(1'b0, crf_pkg::ADDR_CTRL, 32'h0);
		check(rd, 32'h40);
		apb(1'b1, 8'h10, 32'hFFFFFFFF);
		check(err, 1'b1);
	endtask
	task s_cell();
		apb(1'b1, crf_pkg::ADDR_CTRL, 32'h42);
		apb(1'b1, crf_pkg::ADDR_SECONDS, 32'h12345678);
		send(52, 2'h0);
		wait_rec(1);
		chk_rec(crf_pkg::kind_cell, 8'h02, 68, 0, 52, 16);
		check({sink_inst.rec[7], sink_inst.rec[6], sink_inst.rec[5],
			sink_inst.rec[4]}, 32'h12345678);
	endtask
	// Stalled sink: long packet truncates, a packet meanwhile is lost
	task s_drop();
		stall <= 1'b1;
		send(60, 2'h1);
		send(5, 2'h0);
		stall <= 1'b0;
		wait_rec(2);
		chk_rec(8'h03, 8'h1A, 68, 0, 60, 16);
		send(52, 2'h2);
		wait_rec(3);
		chk_rec(8'h03, 8'h22, 68, 1, 52, 16);
	endtask
	task s_lan();
		slow <= 1'b1;
		apb(1'b1, crf_pkg::ADDR_CTRL, 32'h4E);
		send(20, 2'h0);
		wait_rec(4);
		chk_rec(8'h02, 8'h06, 37, 0, 20, 17);
		check(sink_inst.rec[16], 8'h00);
		// Framed mode: framing header and packet stored as they came
		apb(1'b1, crf_pkg::ADDR_CTRL, 32'h52);
		send(24, 2'h0);
		wait_rec(5);
		chk_rec(8'h01, 8'h02, 40, 0, 24, 16);
	endtask
	task pulse();
		@(posedge i_clk);
		i_second_pulse_a <= 1'b1;
		repeat (4) @(posedge i_clk);
		i_second_pulse_a <= 1'b0;
	endtask
	task s_sync();
		int hi;
		hi = 0;
		apb(1'b1, crf_pkg::ADDR_CTRL, 32'h62);
		i_time_serial_b <= 1'b1;
		pulse();
		apb(1'b0, crf_pkg::ADDR_STATUS, 32'h0);
		check(rd[1:0], 2'h2);
		// Master pulse at the local roll-over, counted while waiting
		for (int i = 0; i < SEC - 10; i++)
		begin
			@(posedge i_clk);
			if (o_sync_out_a === 1'b1)
				hi++;
		end
		check(hi, crf_pkg::OUT_PULSE_CYC);
		check(o_sync_out_b, 1'b0);
		pulse();
		repeat (8) @(posedge i_clk);
		apb(1'b0, crf_pkg::ADDR_STATUS, 32'h0);
		check(rd[1:0], 2'h3);
	endtask
	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	initial
	begin
		{i_psel, i_penable, i_pwrite, i_rx_valid, i_rx_last} = '0;
		{i_rx_err, i_rx_int_err, i_second_pulse_a} = '0;
		{i_time_serial_b, stall, slow} = '0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0;
		i_rx_data = 8'h00;
		error_cnt = 0;
		n_compared = 0;
		i_resetn = 1'b0;
		repeat (4) @(posedge i_clk);
		i_resetn <= 1'b1;
		s_regs();
		s_cell();
		s_drop();
		s_lan();
		s_sync();
		finish_test();
	end
endmodule
bind crf_formatter crf_formatter_assertions crf_formatter_assertions_inst (
	.i_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
	.o_prdata, .o_pslverr, .o_rec_valid, .o_rec_data, .o_rec_last,
	.i_rec_ready, .o_sync_out_a);
